// *** dv/smm_host_model.sv ***
// host model: serial master talking to the switch monitor
`timescale 1ns/1ps
module smm_host_model (
    output logic spiClk,
    output logic chip_select_n,
    output logic spiDataIn,
    input wire logic spiDataOut
);
    // idle: clock low and still, port deselected
    initial begin
        spiClk = 1'b0;
        chip_select_n = 1'b1;
        spiDataIn = 1'b0;
    end
    // one framed transfer, msb first, 32 ns bit time
    task automatic xfer(input logic [15:0] cmd, input int nBits,
                        output logic [15:0] rsp);
        rsp = 16'h0000;
        #3;
        chip_select_n = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            spiDataIn = cmd[15-i];
            #16;
            rsp = {rsp[14:0], spiDataOut};
            spiClk = 1'b1;
            #16;
            spiClk = 1'b0;
        end
        #16;
        chip_select_n = 1'b1;
        spiDataIn = ~spiDataIn; // released line shows no stale bit
    endtask : xfer
endmodule : smm_host_model

// *** dv/smm_switch_monitor_properties.sv ***
// concurrent checks on the switch monitor ports
`timescale 1ns/1ps
module smm_switch_monitor_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic chip_select_n,
    input wire logic spiDataOutEn_n,
    input wire logic reset_in_n,
    input wire logic master_slave_strap,
    input wire logic syncOut,
    input wire logic syncOutEn_n,
    input wire logic interrupt_out_n,
    input wire logic interrupt_out_n_en_n,
    input wire logic [1:0] modeOut
);
    // all checks sample on the core clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // serial output floats whenever the port is deselected
    so_float_a: assert property (spiDataOutEn_n == chip_select_n)
        else $error("data out enable does not follow select");
    int_drain_a: assert property (interrupt_out_n == 1'b0)
        else $error("interrupt pin drives high");
    pin_reset_a: assert property (!reset_in_n [*5] |-> modeOut == 2'h0)
        else $error("pin reset left mode awake");
    mode_by_cmd_a: assert property ($changed(modeOut) |-> chip_select_n)
        else $error("mode moved during a transfer");
    int_release_a: assert property (
        $rose(chip_select_n) |-> ##[1:4] interrupt_out_n_en_n)
        else $error("interrupt not released after select rise");
    sleep_quiet_a: assert property (
        modeOut == 2'h0 [*8] |-> interrupt_out_n_en_n)
        else $error("interrupt raised in sleep");
    sync_pulse_a: assert property (
        $rose(syncOut) |-> syncOut [*4] ##1 !syncOut)
        else $error("sync pulse width wrong");
    sync_master_a: assert property (
        syncOut |-> !syncOutEn_n && master_slave_strap)
        else $error("sync driven by a slave");
    strap_enable_a: assert property (
        $stable(master_slave_strap) [*4] |->
        syncOutEn_n == !master_slave_strap)
        else $error("sync enable ignores strap");
    // main scenarios reached
    cover property ($rose(chip_select_n));
    cover property ($fell(interrupt_out_n_en_n));
    cover property ($rose(syncOut));
endmodule : smm_switch_monitor_properties

bind smm_switch_monitor smm_switch_monitor_properties smm_chk_inst (
    .clk, .nrst, .chip_select_n, .spiDataOutEn_n, .reset_in_n,
    .master_slave_strap, .syncOut, .syncOutEn_n, .interrupt_out_n,
    .interrupt_out_n_en_n, .modeOut);

// *** dv/smm_switch_monitor_tb.sv ***
// self-checking bench for the switch monitor
`timescale 1ns/1ps
module smm_switch_monitor_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic spiClk, chip_select_n, spiDataIn, spiDataOut, spiDataOutEn_n;
    logic reset_in_n, master_slave_strap, syncOut, syncOutEn_n;
    logic syncIn, awakeOut;
    logic interrupt_out_n, interrupt_out_n_en_n;
    logic [3:0] programmable_sense_input;
    logic [5:0] ground_sense_input;
    logic [1:0] battery_sense_input, modeOut;
    logic [15:0] r;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    smm_switch_monitor #(.POLL_CYCLES(50), .INT_TIMER_CYCLES(400))
    smm_switch_monitor_inst (
        .clk, .nrst, .spiClk, .chip_select_n, .spiDataIn, .spiDataOut,
        .spiDataOutEn_n, .reset_in_n, .master_slave_strap,
        .programmable_sense_input, .ground_sense_input,
        .battery_sense_input, .syncIn, .syncOut, .syncOutEn_n,
        .interrupt_out_n, .interrupt_out_n_en_n, .modeOut, .awakeOut);
    smm_host_model smm_host_model_inst (
        .spiClk, .chip_select_n, .spiDataIn, .spiDataOut);
    // core clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // frame of a master device: mode, flag, strap, contacts
    function automatic logic [15:0] frm(input logic [1:0] m,
                                        input logic i, input logic [11:0] s);
        return {m, i, 1'b1, s};
    endfunction : frm
    task automatic io(input logic [15:0] cmd);
        smm_host_model_inst.xfer(cmd, 16, r);
        repeat (8) @(negedge clk);
    endtask : io
    task automatic expect_int(input string nm, input int n, input logic w);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < n && !seen; k++) begin
            @(negedge clk);
            seen = (interrupt_out_n_en_n === 1'b0);
        end
        chk(nm, {15'h0000, w}, {15'h0000, seen});
    endtask : expect_int
    task automatic expect_wake(input string nm, input int n, input logic w);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < n && !seen; k++) begin
            @(negedge clk);
            seen = (awakeOut === 1'b1);
        end
        chk(nm, {15'h0000, w}, {15'h0000, seen});
    endtask : expect_wake
    task automatic t_sleep();
        io(16'h0000);
        chk("reset frame", frm(2'h0, 1'b0, 12'h000), r);
        ground_sense_input = 6'h3E;
        expect_wake("sleep wake", 20, 1'b0);
        expect_int("sleep int", 100, 1'b0);
        ground_sense_input = 6'h3F;
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_normal();
        io(16'h4000);
        repeat (10) @(negedge clk);
        battery_sense_input = 2'h2;
        programmable_sense_input = 4'h7;
        expect_wake("normal wake", 50, 1'b1);
        expect_int("normal int", 50, 1'b1);
        io(16'h4000);
        chk("normal frame", frm(2'h1, 1'b1, 12'h802), r);
        chk("int freed", 16'h0001, {15'h0000, interrupt_out_n_en_n});
        smm_host_model_inst.xfer(16'h0000, 8, r);
        repeat (8) @(negedge clk);
        chk("short cmd", 16'h0001, 16'(modeOut));
        $display("test normal done");
    endtask : t_normal
    task automatic t_poll();
        battery_sense_input = 2'h0;
        programmable_sense_input = 4'h0;
        repeat (10) @(negedge clk);
        io(16'h800F);
        expect_int("poll open", 120, 1'b0);
        programmable_sense_input = 4'h1;
        expect_int("poll closed", 120, 1'b1);
        io(16'h800F);
        chk("poll frame", frm(2'h2, 1'b1, 12'h100), r);
        $display("test poll done");
    endtask : t_poll
    task automatic t_timer();
        programmable_sense_input = 4'h0;
        io(16'hC00F);
        expect_int("early timer", 300, 1'b0);
        expect_int("timer int", 200, 1'b1);
        io(16'h4000);
        chk("timer frame", frm(2'h3, 1'b1, 12'h000), r);
        reset_in_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("pin reset", 16'h0000, 16'(modeOut));
        reset_in_n = 1'b1;
        $display("test timer done");
    endtask : t_timer
    // slave device: no own polling, samples on the sync line's rise
    task automatic t_slave();
        master_slave_strap = 1'b0;
        programmable_sense_input = 4'h1;
        repeat (4) @(negedge clk);
        io(16'h800F);
        chk("slave frame", {2'h0, 1'b0, 1'b0, 12'hE00}, r);
        expect_int("slave idle", 120, 1'b0);
        syncIn = 1'b1;
        expect_int("slave sync", 20, 1'b1);
        syncIn = 1'b0;
        chk("slave drive", 16'h0001, {15'h0000, syncOutEn_n});
        $display("test slave done");
    endtask : t_slave
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        reset_in_n = 1'b1;
        master_slave_strap = 1'b1;
        syncIn = 1'b0;
        programmable_sense_input = 4'hF;
        ground_sense_input = 6'h3F;
        battery_sense_input = 2'h0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_sleep();
        t_normal();
        t_poll();
        t_timer();
        t_slave();
        final_report();
    end
endmodule : smm_switch_monitor_tb

// *** src/smm_pkg.sv ***
// shared constants and types of the switch monitor
package smm_pkg;
    localparam int NUM_PROG = 4;
    localparam int NUM_GND = 6;
    localparam int NUM_BATT = 2;
    localparam int NUM_IN = 12;
    localparam int FRAME_BITS = 16;
    localparam int BIT_CNT_W = 5;
    // frame layout: [15:14] mode, [13] interrupt flag, [12] master, [11:0]
    localparam int FRM_MODE_LSB = 14;
    localparam int FRM_INT_BIT = 13;
    localparam int FRM_MS_BIT = 12;
    // command layout: [15:14] mode, [3:0] programmable input polarity
    localparam int CMD_MODE_LSB = 14;
    localparam int CMD_POL_LSB = 0;
    // polling period and interrupt timer, in microseconds
    localparam int POLL_PERIOD_US = 40000;
    localparam int INT_TIMER_US = 320000;
    localparam int CLK_MHZ = 125;
    localparam int POLL_CYCLES = POLL_PERIOD_US * CLK_MHZ;
    localparam int INT_TIMER_CYCLES = INT_TIMER_US * CLK_MHZ;
    localparam int SYNC_PULSE_CYCLES = 4;
    localparam logic [1:0] RESET_MODE = 2'h0;
    localparam logic [3:0] RESET_POL = 4'h0;

    typedef enum logic [1:0] {
        MODE_SLEEP = 2'h0,
        MODE_NORMAL = 2'h1,
        MODE_POLL = 2'h2,
        MODE_POLL_TIMER = 2'h3
    } smm_mode_e;

    typedef struct packed {
        logic [NUM_PROG-1:0] prog;
        logic [NUM_GND-1:0] gnd;
        logic [NUM_BATT-1:0] batt;
    } smm_inputs_s;

    typedef struct packed {
        logic [1:0] mode;
        logic intFlag;
        logic master;
        smm_inputs_s inputs;
    } smm_frame_s;
endpackage : smm_pkg

// *** src/smm_switch_monitor.sv ***
// switch monitor core: input sensing, modes, interrupt and serial port
//
// What this block does
// - sleep mode halts monitoring and stays off until another mode arrives
// - normal mode interrupts the host on any input open/closed change
// - polling mode samples periodically, interrupts only on a closed input
// - polling-timer mode also interrupts when the interrupt timer expires
// - mode changes come only from serial port commands or the reset pin
// - reset returns the device to sleep mode
// - an input change wakes the device in normal and polling modes, never in sleep mode
// - four programmable, six ground and two battery inputs, each reported
// - serial transfers are accepted only while chip select is low
// - a strap input marks the device master or slave
// - sync line lets several devices wake and sample together
// - 16-bit shift, sample on rising edge, shift out falling, MSB first
// - select fall freezes status; select rise releases interrupt, applies
// - each reported input bit is zero open and one closed
// - every frame holds inputs, master flag, interrupt flag and mode
`timescale 1ns/1ps
module smm_switch_monitor #(
    parameter int POLL_CYCLES = smm_pkg::POLL_CYCLES,
    parameter int INT_TIMER_CYCLES = smm_pkg::INT_TIMER_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spiClk,
    input wire logic chip_select_n,
    input wire logic spiDataIn,
    output logic spiDataOut,
    output logic spiDataOutEn_n,
    input wire logic reset_in_n,
    input wire logic master_slave_strap,
    input wire logic [smm_pkg::NUM_PROG-1:0] programmable_sense_input,
    input wire logic [smm_pkg::NUM_GND-1:0] ground_sense_input,
    input wire logic [smm_pkg::NUM_BATT-1:0] battery_sense_input,
    input wire logic syncIn,
    output logic syncOut,
    output logic syncOutEn_n,
    output logic interrupt_out_n,
    output logic interrupt_out_n_en_n,
    output logic [1:0] modeOut,
    output logic awakeOut
);
    localparam int RAW_W = smm_pkg::NUM_IN + 3;
    localparam int PCW = $clog2(POLL_CYCLES + 1);
    localparam int TCW = $clog2(INT_TIMER_CYCLES + 1);

    // contact levels, strap, sync and reset pin into the core clock
    logic [RAW_W-1:0] rawAsync;
    logic [RAW_W-1:0] rawSync;
    assign rawAsync = {reset_in_n, syncIn, master_slave_strap,
                       programmable_sense_input, ground_sense_input,
                       battery_sense_input};

    smm_sync2 #(.WIDTH(RAW_W)) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .asyncIn(rawAsync),
        .syncOut(rawSync)
    );

    logic pinRst_n;
    logic syncLvl;
    logic masterLvl;
    logic [smm_pkg::NUM_PROG-1:0] progLvl;
    logic [smm_pkg::NUM_GND-1:0] gndLvl;
    logic [smm_pkg::NUM_BATT-1:0] battLvl;
    assign {pinRst_n, syncLvl, masterLvl, progLvl, gndLvl, battLvl} = rawSync;

    // command word state in core domain
    logic [1:0] mode_q;
    logic [smm_pkg::NUM_PROG-1:0] pol_q;
    // chip select as seen in the core domain
    logic [1:0] csSync_q;
    logic csLvl_q;
    logic cmdValid_q;
    logic [smm_pkg::FRAME_BITS-1:0] cmdWord;
    logic csRise;
    logic csFall;
    assign csRise = csSync_q[1] & ~csLvl_q;
    assign csFall = ~csSync_q[1] & csLvl_q;

    // closed means one: ground contacts pull low, battery contacts pull high
    smm_pkg::smm_inputs_s closed;
    always_comb begin
        closed.gnd = ~gndLvl;
        closed.batt = battLvl;
        closed.prog = progLvl ^ ~pol_q; // pol 1 = battery sense
    end

    // chip select synchroniser, second stage feeds edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            csSync_q <= 2'h3;
            csLvl_q <= 1'b1;
        end else begin
            csSync_q <= {csSync_q[0], chip_select_n};
            csLvl_q <= csSync_q[1];
        end
    end

    // mode and polarity only change through a completed command or the reset pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= smm_pkg::RESET_MODE;
            pol_q <= smm_pkg::RESET_POL;
        end else if (!pinRst_n) begin
            mode_q <= smm_pkg::MODE_SLEEP;
            pol_q <= smm_pkg::RESET_POL;
        end else if (csRise && cmdValid_q) begin
            mode_q <= cmdWord[smm_pkg::CMD_MODE_LSB +: 2];
            pol_q <= cmdWord[smm_pkg::CMD_POL_LSB +: smm_pkg::NUM_PROG];
        end
    end

    // polling period counter runs only in polling modes on the master
    logic [PCW-1:0] pollCnt_q;
    logic pollTick;
    logic polling;
    assign polling = (mode_q == smm_pkg::MODE_POLL) ||
                     (mode_q == smm_pkg::MODE_POLL_TIMER);
    assign pollTick = polling && masterLvl &&
                      (pollCnt_q == PCW'(POLL_CYCLES - 1));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pollCnt_q <= '0;
        end else if (!polling || !masterLvl || pollTick) begin
            pollCnt_q <= '0;
        end else begin
            pollCnt_q <= pollCnt_q + 1'b1;
        end
    end

    // sync pulse from master, edge detect on slave
    logic [2:0] syncCnt_q;
    logic syncPrev_q;
    logic slaveSample;
    assign slaveSample = polling && !masterLvl && syncLvl && !syncPrev_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncCnt_q <= '0;
            syncPrev_q <= 1'b0;
            syncOut <= 1'b0;
            syncOutEn_n <= 1'b1;
        end else begin
            syncPrev_q <= syncLvl;
            if (pollTick) begin
                syncCnt_q <= 3'(smm_pkg::SYNC_PULSE_CYCLES);
            end else if (syncCnt_q != 3'h0) begin
                syncCnt_q <= syncCnt_q - 1'b1;
            end
            syncOut <= (syncCnt_q != 3'h0);
            syncOutEn_n <= !masterLvl; // master drives the line
        end
    end

    // sample moment: every poll tick or sync edge
    logic sampleNow;
    assign sampleNow = pollTick || slaveSample;

    // tracked contact state and wake flag
    smm_pkg::smm_inputs_s seen_q;
    logic awake_q;
    logic changed;
    assign changed = (closed != seen_q);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seen_q <= '0;
            awake_q <= 1'b0;
        end else if (mode_q == smm_pkg::MODE_SLEEP) begin
            seen_q <= closed; // no monitoring
            awake_q <= 1'b0;
        end else if (mode_q == smm_pkg::MODE_NORMAL) begin
            seen_q <= closed;
            awake_q <= changed;
        end else begin
            awake_q <= sampleNow || changed;
            if (sampleNow) begin
                seen_q <= closed;
            end
        end
    end

    // interrupt timer for polling-with-timer mode
    logic [TCW-1:0] intTmr_q;
    logic tmrExpire;
    assign tmrExpire = (mode_q == smm_pkg::MODE_POLL_TIMER) &&
                       (intTmr_q == TCW'(INT_TIMER_CYCLES - 1));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intTmr_q <= '0;
        end else if (mode_q != smm_pkg::MODE_POLL_TIMER || tmrExpire ||
                     csRise) begin
            intTmr_q <= '0;
        end else begin
            intTmr_q <= intTmr_q + 1'b1;
        end
    end

    // interrupt cause per mode
    logic intEvent;
    always_comb begin
        case (mode_q)
            smm_pkg::MODE_SLEEP: intEvent = 1'b0;
            smm_pkg::MODE_NORMAL: intEvent = changed;
            smm_pkg::MODE_POLL: intEvent = sampleNow && (|closed);
            smm_pkg::MODE_POLL_TIMER:
                intEvent = (sampleNow && (|closed)) || tmrExpire;
            default: intEvent = 1'b0;
        endcase
    end

    // interrupt flag: select rise releases, a fresh event wins over it
    logic intFlag_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intFlag_q <= 1'b0;
        end else if (intEvent) begin
            intFlag_q <= 1'b1;
        end else if (csRise || mode_q == smm_pkg::MODE_SLEEP) begin
            intFlag_q <= 1'b0;
        end
    end

    // open drain interrupt and status outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_out_n <= 1'b0; // open drain never drives high
            interrupt_out_n_en_n <= 1'b1;
            modeOut <= smm_pkg::RESET_MODE;
            awakeOut <= 1'b0;
        end else begin
            interrupt_out_n <= 1'b0; // only ever pulls low
            interrupt_out_n_en_n <= !intFlag_q;
            modeOut <= mode_q;
            awakeOut <= awake_q;
        end
    end

    // status word offered to the link, held steady while selected
    smm_pkg::smm_frame_s status_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= '0;
        end else if (csSync_q[1]) begin
            status_q.mode <= mode_q;
            status_q.intFlag <= intFlag_q;
            status_q.master <= masterLvl;
            status_q.inputs <= closed;
        end
    end

    // link domain, clocked by the serial clock
    // status is stable for the whole frame, so the first falling edge captures it
    localparam logic [smm_pkg::BIT_CNT_W-1:0] FULL_CNT =
        smm_pkg::BIT_CNT_W'(smm_pkg::FRAME_BITS);
    localparam logic [smm_pkg::BIT_CNT_W-1:0] FIRST_CNT =
        smm_pkg::BIT_CNT_W'(1);
    logic [smm_pkg::FRAME_BITS-1:0] shiftIn_q;
    logic [smm_pkg::FRAME_BITS-1:0] shiftOut_q;
    logic [smm_pkg::BIT_CNT_W-1:0] bitCnt_q;
    logic linkFirst_q;
    logic outLoaded_q;

    // rising edge: sample data in, msb first, only while selected
    always_ff @(posedge spiClk) begin
        if (!chip_select_n) begin
            shiftIn_q <= {shiftIn_q[smm_pkg::FRAME_BITS-2:0], spiDataIn};
        end
    end

    // marks the first rising edge of a frame; set again while deselected
    always_ff @(posedge spiClk or posedge chip_select_n or negedge nrst) begin
        if (!nrst || chip_select_n) begin
            linkFirst_q <= 1'b1; // ignored while deselected
        end else begin
            linkFirst_q <= 1'b0;
        end
    end

    // bit count restarts at a frame's first rise and holds after the select
    // rises, so the core still sees it when it applies the word; a select
    // pulse with no clock edge at all re-applies the last full command
    always_ff @(posedge spiClk or negedge nrst) begin
        if (!nrst) begin
            bitCnt_q <= '0;
        end else if (!chip_select_n) begin
            if (linkFirst_q) begin
                bitCnt_q <= FIRST_CNT;
            end else if (bitCnt_q != FULL_CNT) begin
                bitCnt_q <= bitCnt_q + 1'b1; // one edge per bit
            end
        end
    end

    // falling edge: next bit out, msb first; the first fall loads the frame
    always_ff @(negedge spiClk or posedge chip_select_n or negedge nrst) begin
        if (!nrst || chip_select_n) begin
            shiftOut_q <= '0;
            outLoaded_q <= 1'b0;
        end else if (!outLoaded_q) begin
            shiftOut_q <= {status_q[smm_pkg::FRAME_BITS-2:0], 1'b0};
            outLoaded_q <= 1'b1;
        end else begin
            shiftOut_q <= {shiftOut_q[smm_pkg::FRAME_BITS-2:0], 1'b0};
        end
    end

    // data pin: bit 15 of the frozen status until the first falling edge
    always_comb begin
        spiDataOut = outLoaded_q ? shiftOut_q[smm_pkg::FRAME_BITS-1]
                                 : status_q[smm_pkg::FRAME_BITS-1];
        spiDataOutEn_n = chip_select_n; // floats when deselected
    end

    // received word is stable after the select rises; core reads it then
    always_comb begin
        cmdWord = shiftIn_q;
    end

    // completed word flag: full 16 bits counted, read after select rise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmdValid_q <= 1'b0;
        end else begin
            cmdValid_q <= (bitCnt_q == FULL_CNT);
        end
    end
endmodule : smm_switch_monitor

// *** src/smm_sync2.sv ***
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module smm_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : smm_sync2
